// file: bench/fsp_host_model.sv
// serial host model driving mode-0 frames into the flash block
`timescale 1ns/1ns
module fsp_host_model (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe_n
);
    // ***************
    // frame engine
    // ***************
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // clock stands low between frames; an undriven output reads inverted
    task automatic frame(input logic [31:0] wr, input int nw, input int nr, output logic [15:0] rd);
        rd = '0;
        #1 cs_n = 1'b0;
        for (int i = nw - 1; i >= 0; i--)
        begin
            si = wr[i];
            #160 sck = 1'b1;
            #160 sck = 1'b0;
        end
        for (int i = 0; i < nr; i++)
        begin
            si = ~si;
            #160 sck = 1'b1;
            rd = {rd[14:0], so ^ so_oe_n};
            #160 sck = 1'b0;
        end
        #160 cs_n = 1'b1;
        si = ~si;
        #199;
    endtask
endmodule

// file: bench/tb_fsp_status_protect.sv
// self-checking bench for the flash status and block protection block
`timescale 1ns/1ns
module tb_fsp_status_protect;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, so, so_oe_n, ecc_en, idr_en, hs_en;
    fsp_pkg::fsp_req_t req;
    fsp_pkg::fsp_ack_t ack = '0;
    fsp_pkg::fsp_ecc_t ecc = '0;
    int fails = 0;
    int checks_done = 0;
    int starts = 0;
    int cyc = 0;
    logic [15:0] rd;
    always #20 clk = ~clk;
    fsp_status_protect u_fsp_status_protect (.CLK(clk), .RST(rst), .SCK(sck), .CS_N(cs_n), .SI(si),
        .WP_N(wp_n), .SO(so), .SO_OE_N(so_oe_n), .ARRAY_REQ(req), .ARRAY_ACK(ack), .ECC_IN(ecc),
        .ECC_ENABLE(ecc_en), .ID_READ_ENABLE(idr_en), .HIGH_SPEED(hs_en));
    fsp_host_model u_fsp_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
    // ***************
    // helpers
    // ***************
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (req.start === 1'b1)
            starts <= starts + 1;
        if (cyc == 60000)
        begin
            fails = fails + 1;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic sf(input logic [7:0] a, input logic [7:0] d);
        u_fsp_host_model.frame({8'h00, fsp_pkg::CMD_SETF, a, d}, 24, 0, rd);
    endtask
    // two bytes read back to show the byte repeats
    task automatic gf(input logic [7:0] a, input logic [15:0] exp);
        u_fsp_host_model.frame({16'h0000, fsp_pkg::CMD_GETF, a}, 16, 16, rd);
        chk(rd, exp);
    endtask
    task automatic op(input logic [7:0] c);
        u_fsp_host_model.frame({24'h000000, c}, 8, 0, rd);
    endtask
    task automatic ex(input logic [7:0] c, input logic [9:0] blk, input int n);
        int s0;
        op(fsp_pkg::CMD_WREN);
        s0 = starts;
        u_fsp_host_model.frame({c, 8'h00, blk, 6'h00}, 32, 0, rd);
        chk(16'(starts - s0), 16'(n));
    endtask
    task automatic fin(input logic f);
        @(posedge clk);
        #1 ack = '{done: 1'b1, fail: f};
        @(posedge clk);
        #1 ack = '0;
    endtask
    task automatic ep(input logic [5:0] v);
        @(posedge clk);
        #1 ecc = v;
        @(posedge clk);
        #1 ecc = '0;
    endtask
    // ***************
    // scenarios
    // ***************
    task automatic t_ecc();
        logic [5:0] in [4] = '{6'h22, 6'h23, 6'h30, 6'h20};
        logic [7:0] st [4] = '{8'h10, 8'h30, 8'h20, 8'h00};
        sf(fsp_pkg::FA_THR, 8'h30);
        for (int i = 0; i < 4; i++)
        begin
            ep(in[i]);
            gf(fsp_pkg::FA_STAT, {2{st[i]}});
        end
        ep(6'h30);
        sf(fsp_pkg::FA_CFG, 8'h42);
        chk(16'({ecc_en, idr_en, hs_en}), 16'h0003);
        gf(fsp_pkg::FA_CFG, 16'h4646);
        gf(fsp_pkg::FA_STAT, 16'h0000);
        sf(fsp_pkg::FA_CFG, 8'h14);
        gf(fsp_pkg::FA_STAT, 16'h2020);
        // leave a clean ecc code for the scenarios that follow
        ep(6'h20);
    endtask
    task automatic t_wel();
        op(fsp_pkg::CMD_WREN);
        sf(fsp_pkg::FA_STAT, 8'h00);
        gf(fsp_pkg::FA_STAT, 16'h0202);
        op(fsp_pkg::CMD_WRDI);
        gf(fsp_pkg::FA_STAT, 16'h0000);
    endtask
    task automatic t_lock();
        logic [9:0] first [7] = '{10'h3F0, 10'h3E0, 10'h3C0, 10'h380, 10'h300, 10'h200, 10'h000};
        for (int c = 1; c < 8; c++)
        begin
            sf(fsp_pkg::FA_LOCK, 8'(c << 3));
            ex(fsp_pkg::CMD_ERASE, first[c-1], 0);
            gf(fsp_pkg::FA_STAT, 16'h0404);
            if (c < 7)
            begin
                ex(fsp_pkg::CMD_ERASE, first[c-1] - 10'h001, 1);
                fork
                    gf(fsp_pkg::FA_STAT, 16'h0700);
                    begin
                        repeat (160) @(posedge clk);
                        fin(1'b0);
                    end
                join
            end
        end
    endtask
    task automatic t_prot();
        sf(fsp_pkg::FA_LOCK, 8'h00);
        ex(fsp_pkg::CMD_PROT, 10'h380, 0);
        gf(fsp_pkg::FA_STAT, 16'h0C0C);
        // enable then write enable, once per block
        sf(fsp_pkg::FA_CFG, 8'h94);
        ex(fsp_pkg::CMD_PROT, 10'h380, 1);
        chk({14'h0000, req.kind}, 16'(fsp_pkg::OP_PROT));
        chk(req.row, 16'hE000);
        gf(fsp_pkg::FA_STAT, 16'h0F0F);
        fin(1'b0);
        gf(fsp_pkg::FA_STAT, 16'h0404);
        sf(fsp_pkg::FA_CFG, 8'h14);
        sf(fsp_pkg::FA_CFG, 8'h94);
        ex(fsp_pkg::CMD_PROT, 10'h37F, 0);
        sf(fsp_pkg::FA_CFG, 8'h14);
        gf(fsp_pkg::FA_STAT, 16'h0C0C);
        ex(fsp_pkg::CMD_PEXE, 10'h380, 0);
        ex(fsp_pkg::CMD_ERASE, 10'h000, 1);
        fin(1'b0);
        ex(fsp_pkg::CMD_PEXE, 10'h3FF, 1);
        fin(1'b0);
        gf(fsp_pkg::FA_STAT, 16'h0000);
        ex(fsp_pkg::CMD_ERASE, 10'h001, 1);
        fin(1'b1);
        gf(fsp_pkg::FA_STAT, 16'h0404);
    endtask
    task automatic t_wp();
        @(posedge clk);
        #1 wp_n = 1'b0;
        sf(fsp_pkg::FA_LOCK, 8'h88);
        gf(fsp_pkg::FA_LOCK, 16'h8888);
        ex(fsp_pkg::CMD_PEXE, 10'h3F0, 0);
        gf(fsp_pkg::FA_STAT, 16'h0C0C);
        sf(fsp_pkg::FA_LOCK, 8'h00);
        gf(fsp_pkg::FA_LOCK, 16'h8888);
        @(posedge clk);
        #1 wp_n = 1'b1;
        sf(fsp_pkg::FA_LOCK, 8'h00);
        op(8'hFF);
        gf(fsp_pkg::FA_LOCK, 16'h0000);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        gf(fsp_pkg::FA_LOCK, 16'h3838);
        gf(fsp_pkg::FA_CFG, 16'h1414);
        gf(fsp_pkg::FA_THR, 16'h1010);
        t_ecc();
        t_wel();
        t_lock();
        t_prot();
        t_wp();
        end_sim();
    end
endmodule

// file: verilog/fsp_pkg.sv
// shared constants and carrier types for the flash status and protection block
package fsp_pkg;

    // command opcodes
    localparam logic [7:0] CMD_WREN = 8'h06;
    localparam logic [7:0] CMD_WRDI = 8'h04;
    localparam logic [7:0] CMD_SETF = 8'h1F;
    localparam logic [7:0] CMD_GETF = 8'h0F;
    localparam logic [7:0] CMD_PEXE = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'hD8;
    localparam logic [7:0] CMD_PROT = 8'h2A;

    // feature addresses
    localparam logic [7:0] FA_LOCK = 8'hA0;
    localparam logic [7:0] FA_CFG = 8'hB0;
    localparam logic [7:0] FA_STAT = 8'hC0;
    localparam logic [7:0] FA_THR = 8'h10;

    // field positions
    localparam int LOCK_WD_BIT = 7;
    localparam int LOCK_HI = 5;
    localparam int LOCK_LO = 3;
    localparam int CFG_PRT = 7;
    localparam int CFG_IDR = 6;
    localparam int CFG_ECC = 4;
    localparam int CFG_HSE = 1;
    localparam int THR_HI = 7;
    localparam int THR_LO = 4;
    localparam int ST_OIP = 0;

    // reset values
    localparam logic [2:0] LOCK_RST = 3'h7;
    localparam logic ECC_EN_RST = 1'b1;
    localparam logic BBI_VAL = 1'b1;
    localparam logic [3:0] THR_RST = 4'h1;

    // ecc outcome codes
    localparam logic [1:0] ECC_NONE = 2'h0;
    localparam logic [1:0] ECC_CORR_LO = 2'h1;
    localparam logic [1:0] ECC_UNCORR = 2'h2;
    localparam logic [1:0] ECC_CORR_HI = 2'h3;

    // block geometry and lock range starts
    localparam int PAGE_BITS = 6;
    localparam logic [9:0] PROT_FIRST = 10'h380;
    localparam logic [9:0] LOCK_1_64 = 10'h3F0;
    localparam logic [9:0] LOCK_1_32 = 10'h3E0;
    localparam logic [9:0] LOCK_1_16 = 10'h3C0;
    localparam logic [9:0] LOCK_1_8 = 10'h380;
    localparam logic [9:0] LOCK_1_4 = 10'h300;
    localparam logic [9:0] LOCK_1_2 = 10'h200;
    localparam logic [4:0] FEAT_LAST = 5'h07;
    localparam logic [4:0] ROW_LAST = 5'h17;

    typedef enum logic [1:0] {OP_PROG = 2'h0, OP_ERASE = 2'h1, OP_PROT = 2'h2} fsp_op_t;

    typedef struct packed {
        logic start;
        fsp_op_t kind;
        logic [15:0] row;
    } fsp_req_t;

    typedef struct packed {
        logic done;
        logic fail;
    } fsp_ack_t;

    typedef struct packed {
        logic valid;
        logic uncorr;
        logic [3:0] flips;
    } fsp_ecc_t;

endpackage

// file: verilog/fsp_status_protect.sv
// serial flash status byte, feature registers, block lock and one-time protection
`timescale 1ns/1ns

// Functional notes
// - two-bit ecc outcome of last page read
// - threshold nibble picks corrected code
// - program fail tracks program/protect result
// - erase fail tracks erase result
// - latch set by enable, cleared by disable, refusal or completion
// - busy bit high exactly while busy
// - feature byte repeats until chip select high
// - busy and fail bits refresh live
// - locked range blocks program/protect/erase
// - locked target flags fail, array untouched
// - lock field bits five..three at A0h
// - lock field resets to all ones
// - lock code selects upper fraction locked
// - write-disable plus low WP freezes lock
// - only last 128 blocks protectable
// - protection cleared only by RST
// - protect execute with enable protects block
// - reserved bits read zero
// - features survive reset commands
// - ecc bits meaningful only with ecc on
module fsp_status_protect (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic WP_N,
    output logic SO,
    output logic SO_OE_N,
    output fsp_pkg::fsp_req_t ARRAY_REQ,
    input wire fsp_pkg::fsp_ack_t ARRAY_ACK,
    input wire fsp_pkg::fsp_ecc_t ECC_IN,
    output logic ECC_ENABLE,
    output logic ID_READ_ENABLE,
    output logic HIGH_SPEED
);
    typedef enum logic [4:0] {
        S_CMD = 5'h01,
        S_ADDR = 5'h02,
        S_DATA = 5'h04,
        S_OUT = 5'h08,
        S_SKIP = 5'h10
    } fsp_state_t;

    logic [3:0] pin_s;
    logic sck_s, cs_n_s, si_s, wp_n_s, sck_d_r;
    logic sck_rise, sck_fall;
    fsp_state_t st_r, st_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [23:0] sh_r;
    logic [7:0] cmd_r, fa_r, byte_in, feat_rd, stat_byte;
    logic [15:0] row_in;
    logic wren_ev, wrdi_ev, setf_ev, exec_ev, cmd_ld, fa_ld;
    logic lock_wd_r, prt_r, idr_r, ecc_en_r, hse_r;
    logic [2:0] lock_r;
    logic [3:0] thr_r;
    logic [1:0] ecc_r;
    logic prg_fail_r, ers_fail_r, wel_r, busy_r;
    fsp_pkg::fsp_req_t req_r;
    fsp_pkg::fsp_op_t op_r;
    logic [6:0] blk_r;
    logic [127:0] prot_r;
    logic [9:0] blk;
    logic locked, prot_hit, lock_frozen;
    logic [2:0] out_cnt_r;
    logic [7:0] out_sr_r;
    logic so_r, oe_n_r;

    // pins cross in through two flops; the link clock is just sampled
    fsp_sync #(.W(4)) u_sync (
        .clk(CLK),
        .rst(RST),
        .d({SCK, CS_N, SI, WP_N}),
        .q(pin_s)
    );
    assign {sck_s, cs_n_s, si_s, wp_n_s} = pin_s;

    always_ff @(posedge CLK)
    begin
        if (RST)
            sck_d_r <= 1'b1;
        else
            sck_d_r <= sck_s;
    end
    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;

    assign byte_in = {sh_r[6:0], si_s};
    assign row_in = {sh_r[14:0], si_s};

    // ****************************************
    // serial frame decoder
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        bit_cnt_nxt = bit_cnt_r;
        wren_ev = 1'b0;
        wrdi_ev = 1'b0;
        setf_ev = 1'b0;
        exec_ev = 1'b0;
        cmd_ld = 1'b0;
        fa_ld = 1'b0;
        if (cs_n_s)
        begin
            st_nxt = S_CMD;
            bit_cnt_nxt = 5'h00;
        end
        else if (sck_rise)
        begin
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            case (st_r)
                S_CMD:
                begin
                    if (bit_cnt_r == fsp_pkg::FEAT_LAST)
                    begin
                        bit_cnt_nxt = 5'h00;
                        cmd_ld = 1'b1;
                        st_nxt = S_SKIP;
                        // only get feature, at any address, is served while busy
                        if (byte_in == fsp_pkg::CMD_GETF)
                            st_nxt = S_ADDR;
                        else if (!busy_r)
                        begin
                            case (byte_in)
                                fsp_pkg::CMD_WREN: wren_ev = 1'b1;
                                fsp_pkg::CMD_WRDI: wrdi_ev = 1'b1;
                                fsp_pkg::CMD_SETF, fsp_pkg::CMD_PEXE, fsp_pkg::CMD_ERASE, fsp_pkg::CMD_PROT:
                                    st_nxt = S_ADDR;
                                // reset opcodes leave feature bits alone
                                default: st_nxt = S_SKIP;
                            endcase
                        end
                    end
                end
                S_ADDR:
                begin
                    if (cmd_r == fsp_pkg::CMD_SETF || cmd_r == fsp_pkg::CMD_GETF)
                    begin
                        if (bit_cnt_r == fsp_pkg::FEAT_LAST)
                        begin
                            fa_ld = 1'b1;
                            bit_cnt_nxt = 5'h00;
                            st_nxt = (cmd_r == fsp_pkg::CMD_GETF) ? S_OUT : S_DATA;
                        end
                    end
                    else if (bit_cnt_r == fsp_pkg::ROW_LAST)
                    begin
                        exec_ev = 1'b1;
                        st_nxt = S_SKIP;
                    end
                end
                S_DATA:
                begin
                    if (bit_cnt_r == fsp_pkg::FEAT_LAST)
                    begin
                        setf_ev = 1'b1;
                        st_nxt = S_SKIP;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_r <= S_CMD;
            bit_cnt_r <= 5'h00;
            sh_r <= 24'h000000;
            cmd_r <= 8'h00;
            fa_r <= 8'h00;
        end
        else
        begin
            st_r <= st_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            if (sck_rise && !cs_n_s)
                sh_r <= {sh_r[22:0], si_s};
            if (cmd_ld)
                cmd_r <= byte_in;
            if (fa_ld)
                fa_r <= byte_in;
        end
    end

    // ****************************************
    // feature registers
    // ****************************************
    // lock write guard
    assign lock_frozen = lock_wd_r & ~wp_n_s;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            lock_wd_r <= 1'b0;
            lock_r <= fsp_pkg::LOCK_RST;
            prt_r <= 1'b0;
            idr_r <= 1'b0;
            ecc_en_r <= fsp_pkg::ECC_EN_RST;
            hse_r <= 1'b0;
            thr_r <= fsp_pkg::THR_RST;
        end
        else if (setf_ev)
        begin
            case (fa_r)
                fsp_pkg::FA_LOCK:
                begin
                    if (!lock_frozen)
                    begin
                        lock_wd_r <= byte_in[fsp_pkg::LOCK_WD_BIT];
                        lock_r <= byte_in[fsp_pkg::LOCK_HI:fsp_pkg::LOCK_LO];
                    end
                end
                fsp_pkg::FA_CFG:
                begin
                    prt_r <= byte_in[fsp_pkg::CFG_PRT];
                    idr_r <= byte_in[fsp_pkg::CFG_IDR];
                    ecc_en_r <= byte_in[fsp_pkg::CFG_ECC];
                    hse_r <= byte_in[fsp_pkg::CFG_HSE];
                end
                fsp_pkg::FA_THR: thr_r <= byte_in[fsp_pkg::THR_HI:fsp_pkg::THR_LO];
                // status address write is a no-op: the latch is not reachable here
                default: ;
            endcase
        end
    end

    assign ECC_ENABLE = ecc_en_r;
    assign ID_READ_ENABLE = idr_r;
    assign HIGH_SPEED = hse_r;

    // ****************************************
    // ecc outcome
    // ****************************************
    // outcome and threshold
    always_ff @(posedge CLK)
    begin
        if (RST)
            ecc_r <= fsp_pkg::ECC_NONE;
        else if (ECC_IN.valid)
        begin
            if (ECC_IN.uncorr)
                ecc_r <= fsp_pkg::ECC_UNCORR;
            else if (ECC_IN.flips == 4'h0)
                ecc_r <= fsp_pkg::ECC_NONE;
            else if (ECC_IN.flips < thr_r)
                ecc_r <= fsp_pkg::ECC_CORR_LO;
            else
                ecc_r <= fsp_pkg::ECC_CORR_HI;
        end
    end

    // ****************************************
    // lock and protection checks
    // ****************************************
    function automatic logic [9:0] lock_first(input logic [2:0] code);
        case (code)
            3'h1: lock_first = fsp_pkg::LOCK_1_64;
            3'h2: lock_first = fsp_pkg::LOCK_1_32;
            3'h3: lock_first = fsp_pkg::LOCK_1_16;
            3'h4: lock_first = fsp_pkg::LOCK_1_8;
            3'h5: lock_first = fsp_pkg::LOCK_1_4;
            3'h6: lock_first = fsp_pkg::LOCK_1_2;
            default: lock_first = 10'h000;
        endcase
    endfunction

    assign blk = row_in[15:fsp_pkg::PAGE_BITS];
    assign locked = (lock_r != 3'h0) && (blk >= lock_first(lock_r));
    assign prot_hit = (blk >= fsp_pkg::PROT_FIRST) && prot_r[blk[6:0]];

    // ****************************************
    // status bits and array requests
    // ****************************************
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            prg_fail_r <= 1'b0;
            ers_fail_r <= 1'b0;
            wel_r <= 1'b0;
            busy_r <= 1'b0;
            req_r <= '0;
            op_r <= fsp_pkg::OP_PROG;
            blk_r <= 7'h00;
        end
        else
        begin
            req_r.start <= 1'b0;
            // latch by its own commands; refusals and completion also clear it
            if (wren_ev)
                wel_r <= 1'b1;
            if (wrdi_ev)
                wel_r <= 1'b0;
            if (exec_ev && wel_r)
            begin
                req_r.row <= row_in;
                blk_r <= blk[6:0];
                case (cmd_r)
                    fsp_pkg::CMD_PROT:
                    begin
                        op_r <= fsp_pkg::OP_PROT;
                        req_r.kind <= fsp_pkg::OP_PROT;
                        if (locked || !prt_r || blk < fsp_pkg::PROT_FIRST)
                        begin
                            prg_fail_r <= 1'b1;
                            wel_r <= 1'b0;
                        end
                        else
                        begin
                            req_r.start <= 1'b1;
                            busy_r <= 1'b1;
                        end
                    end
                    default:
                    begin
                        op_r <= (cmd_r == fsp_pkg::CMD_ERASE) ? fsp_pkg::OP_ERASE : fsp_pkg::OP_PROG;
                        req_r.kind <= (cmd_r == fsp_pkg::CMD_ERASE) ? fsp_pkg::OP_ERASE : fsp_pkg::OP_PROG;
                        if (locked || prot_hit)
                        begin
                            if (cmd_r == fsp_pkg::CMD_ERASE)
                                ers_fail_r <= 1'b1;
                            else
                                prg_fail_r <= 1'b1;
                            wel_r <= 1'b0;
                        end
                        else
                        begin
                            req_r.start <= 1'b1;
                            busy_r <= 1'b1;
                        end
                    end
                endcase
            end
            if (busy_r && ARRAY_ACK.done)
            begin
                busy_r <= 1'b0;
                wel_r <= 1'b0;
                if (op_r == fsp_pkg::OP_ERASE)
                    ers_fail_r <= ARRAY_ACK.fail;
                else
                    prg_fail_r <= ARRAY_ACK.fail;
            end
        end
    end
    assign ARRAY_REQ = req_r;

    always_ff @(posedge CLK)
    begin
        if (RST)
            prot_r <= '0;
        else if (busy_r && ARRAY_ACK.done && op_r == fsp_pkg::OP_PROT && !ARRAY_ACK.fail)
            prot_r[blk_r] <= 1'b1;
    end

    // ****************************************
    // feature readback and serial output
    // ****************************************
    // reserved zero, ecc gated
    assign stat_byte = {2'h0, ecc_en_r ? ecc_r : fsp_pkg::ECC_NONE, prg_fail_r, ers_fail_r, wel_r, busy_r};

    always_comb
    begin
        case (fa_r)
            fsp_pkg::FA_LOCK: feat_rd = {lock_wd_r, 1'b0, lock_r, 3'h0};
            fsp_pkg::FA_CFG: feat_rd = {prt_r, idr_r, 1'b0, ecc_en_r, 1'b0, fsp_pkg::BBI_VAL, hse_r, 1'b0};
            fsp_pkg::FA_STAT: feat_rd = stat_byte;
            fsp_pkg::FA_THR: feat_rd = {thr_r, 4'h0};
            default: feat_rd = 8'h00;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            out_cnt_r <= 3'h0;
            out_sr_r <= 8'h00;
            so_r <= 1'b0;
            oe_n_r <= 1'b1;
        end
        else
        begin
            oe_n_r <= !(st_r == S_OUT && !cs_n_s);
            if (cs_n_s)
                out_cnt_r <= 3'h0;
            else if (sck_fall && st_r == S_OUT)
            begin
                out_cnt_r <= out_cnt_r + 3'h1;
                if (out_cnt_r == 3'h0)
                begin
                    so_r <= feat_rd[7];
                    out_sr_r <= {feat_rd[6:0], 1'b0};
                end
                else
                begin
                    so_r <= out_sr_r[7];
                    out_sr_r <= {out_sr_r[6:0], 1'b0};
                end
            end
        end
    end
    assign SO = so_r;
    assign SO_OE_N = oe_n_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    chk_lock_reset: assert property ($fell(RST) |-> lock_r == fsp_pkg::LOCK_RST) else $error("lock not all ones");
    chk_wel_setf: assert property (setf_ev |=> $stable(wel_r)) else $error("set feature moved latch");
    chk_busy_start: assert property (busy_r && !ARRAY_ACK.done |=> stat_byte[fsp_pkg::ST_OIP])
        else $error("busy bit dropped before completion");
    chk_ecc_uncorr: assert property (ECC_IN.valid && ECC_IN.uncorr && ecc_en_r |=> stat_byte[5:4] == 2'h2)
        else $error("uncorrectable not reported");
    chk_ecc_thresh: assert property (ECC_IN.valid && !ECC_IN.uncorr && ECC_IN.flips != 4'h0
        && ECC_IN.flips >= thr_r |=> ecc_r == 2'h3) else $error("threshold code wrong");
    chk_lock_refuse: assert property (exec_ev && wel_r && locked && cmd_r == fsp_pkg::CMD_PEXE
        |=> prg_fail_r && !req_r.start && !wel_r) else $error("locked program not refused");
    chk_prg_result: assert property (busy_r && ARRAY_ACK.done && op_r == fsp_pkg::OP_PROG
        |=> prg_fail_r == $past(ARRAY_ACK.fail) && !busy_r && !wel_r) else $error("program result lost");
    chk_ers_result: assert property (busy_r && ARRAY_ACK.done && op_r == fsp_pkg::OP_ERASE
        |=> ers_fail_r == $past(ARRAY_ACK.fail)) else $error("erase result lost");
    chk_lock_frozen: assert property (setf_ev && fa_r == fsp_pkg::FA_LOCK && lock_wd_r && !wp_n_s
        |=> $stable(lock_r) && lock_wd_r) else $error("frozen lock changed");
    chk_prot_perm: assert property ((($past(prot_r) & ~prot_r) == '0)) else $error("protection removed");
    chk_prot_range: assert property (exec_ev && wel_r && cmd_r == fsp_pkg::CMD_PROT && blk < fsp_pkg::PROT_FIRST
        |=> prg_fail_r && !busy_r) else $error("low block protect accepted");
    chk_out_release: assert property (cs_n_s |=> SO_OE_N) else $error("output driven after deselect");

    cov_status_poll: cover property (st_r == S_OUT && fa_r == fsp_pkg::FA_STAT && sck_fall && busy_r);
    cov_protect_done: cover property (busy_r && ARRAY_ACK.done && op_r == fsp_pkg::OP_PROT && !ARRAY_ACK.fail);
    cov_lock_refused: cover property (exec_ev && wel_r && locked);
    cov_erase_start: cover property (req_r.start && req_r.kind == fsp_pkg::OP_ERASE);
endmodule

// file: verilog/fsp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module fsp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= '1;
            q <= '1;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
